// ---- verilog/sacc_conv_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module sacc_conv_ctrl (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      sys_rst,
    // Special function register bus
    input  wire sacc_pkg::sacc_sfr_req_t   sfr_req,
    output logic [7:0]                     sfr_rdata_ff,
    // Power modes and auxiliary control bits
    input  wire sacc_pkg::sacc_pwr_t       pwr,
    // Interrupt controller
    input  wire logic                      irq_enable,
    output logic                           conv_irq_req,
    // Analog front end
    input  wire logic                      comp_above,
    output logic [sacc_pkg::CHAN_W-1:0]    chan_ff,
    output logic                           mux_en_ff,
    output logic                           sample_switch_ff,
    output logic [sacc_pkg::RES_W-1:0]     dac_code
);

    sacc_pkg::sacc_state_t             state_ff;
    sacc_pkg::sacc_state_t             nxt_state;
    logic                              done_ff;
    logic                              nxt_done;
    logic                              busy_ff;
    logic                              nxt_busy;
    logic                              mode8_ff;
    logic                              nxt_mode8;
    logic [sacc_pkg::CHAN_W-1:0]       nxt_chan;
    logic                              nxt_sample;
    logic                              nxt_mux_en;
    logic [sacc_pkg::RES_W-1:0]        result_ff;
    logic [sacc_pkg::RES_W-1:0]        nxt_result;
    logic [7:0]                        nxt_rdata;
    logic [sacc_pkg::CYC_W-1:0]        cyc;
    logic [sacc_pkg::CYC_W-1:0]        cyc_plus;
    logic [sacc_pkg::RES_W-1:0]        decided;
    logic                              wr_ctrl;
    logic                              wr_clears_done;
    logic                              conv_en;
    logic                              start_ev;
    logic                              abort_ev;
    logic                              done_ev;
    logic                              sar_load;
    logic                              sar_step;
    logic                              abort_seen_ff;

    // Step edges fall every bit period after the sampling window
    function automatic logic step_due(input logic [5:0] c, input logic m8);
        logic [5:0] rel;
        rel = c - sacc_pkg::CONV_START;
        if (m8) begin
            step_due = 1'b1;
        end else begin
            step_due = ((rel & (sacc_pkg::BIT_CYC_10 - 6'h01)) == 6'h00);
        end
    endfunction

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    sacc_cycle_timer #(
        .W        (sacc_pkg::CYC_W)
    ) u_timer (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .clr      (start_ev),
        .run      (state_ff != sacc_pkg::ST_IDLE),
        .count_ff (cyc)
    );

    sacc_sar_reg #(
        .W          (sacc_pkg::RES_W),
        .LSB8       (sacc_pkg::RES8_LSB)
    ) u_sar (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .load       (sar_load),
        .step       (sar_step),
        .mode8      (mode8_ff),
        .comp_above (comp_above),
        .trial_ff   (dac_code),
        .decided    (decided)
    );

    // ------------------------------------------------------------------
    // Start, abort and sequencing
    // ------------------------------------------------------------------
    always_comb begin
        wr_ctrl        = sfr_req.wr && (sfr_req.addr == sacc_pkg::ADDR_CTRL);
        wr_clears_done = wr_ctrl && !sfr_req.wdata[sacc_pkg::CTRL_DONE_POS];
        cyc_plus       = cyc + 6'h01;
        conv_en = !pwr.power_down && (!pwr.idle_mode || pwr.idle_keep_converter_on);
        start_ev = wr_ctrl && sfr_req.wdata[sacc_pkg::CTRL_START_POS] && conv_en
                   && (state_ff == sacc_pkg::ST_IDLE) && !busy_ff
                   && (!done_ff || wr_clears_done);
        abort_ev = !conv_en && (state_ff != sacc_pkg::ST_IDLE);
        done_ev  = !abort_ev && (state_ff == sacc_pkg::ST_CONVERT)
                   && (cyc_plus == (mode8_ff ? sacc_pkg::TOTAL_8 : sacc_pkg::TOTAL_10));
        sar_load = !abort_ev && (state_ff == sacc_pkg::ST_SAMPLE)
                   && (cyc_plus == sacc_pkg::CONV_START);
        sar_step = !abort_ev && (state_ff == sacc_pkg::ST_CONVERT)
                   && (cyc_plus > sacc_pkg::CONV_START) && step_due(cyc_plus, mode8_ff);
    end

    always_comb begin
        nxt_state  = state_ff;
        nxt_mode8  = mode8_ff;
        nxt_busy   = busy_ff;
        nxt_sample = 1'b0;
        case (state_ff)
            sacc_pkg::ST_IDLE: begin
                if (start_ev) begin
                    nxt_state = sacc_pkg::ST_INIT;
                    nxt_mode8 = pwr.eight_bit_mode_select;
                end
            end
            sacc_pkg::ST_INIT: begin
                nxt_busy = 1'b1;
                if (cyc_plus == sacc_pkg::INIT_CYC) begin
                    nxt_state  = sacc_pkg::ST_SAMPLE;
                    nxt_sample = 1'b1;
                end
            end
            sacc_pkg::ST_SAMPLE: begin
                nxt_sample = !sar_load;
                if (sar_load) begin
                    nxt_state = sacc_pkg::ST_CONVERT;
                end
            end
            sacc_pkg::ST_CONVERT: begin
                if (done_ev) begin
                    nxt_state = sacc_pkg::ST_CLOSE;
                end
            end
            sacc_pkg::ST_CLOSE: begin
                nxt_busy  = 1'b0;
                nxt_state = sacc_pkg::ST_IDLE;
            end
            default: begin
                nxt_state = sacc_pkg::ST_IDLE;
            end
        endcase
        if (abort_ev) begin
            nxt_state  = sacc_pkg::ST_IDLE;
            nxt_busy   = 1'b0;
            nxt_sample = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Flag, channel and result registers
    // ------------------------------------------------------------------
    always_comb begin
        nxt_done = done_ev || (done_ff && !wr_clears_done);
        nxt_chan = chan_ff;
        if (wr_ctrl && !done_ff && !busy_ff && (state_ff == sacc_pkg::ST_IDLE)) begin
            nxt_chan = sfr_req.wdata[sacc_pkg::CTRL_CHAN_HI:sacc_pkg::CTRL_CHAN_LO];
        end
        // undefined codes keep the mux off
        nxt_mux_en = nxt_sample && (chan_ff < sacc_pkg::CHAN_COUNT);
        nxt_result = done_ev ? decided : result_ff;
    end

    assign conv_irq_req = done_ff && irq_enable;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        nxt_rdata = sacc_pkg::RDATA_NONE;
        if (sfr_req.rd && (sfr_req.addr == sacc_pkg::ADDR_CTRL)) begin
            nxt_rdata                            = sacc_pkg::CTRL_RESET;
            nxt_rdata[sacc_pkg::CTRL_RES1_POS]   = result_ff[1];
            nxt_rdata[sacc_pkg::CTRL_RES0_POS]   = result_ff[0];
            nxt_rdata[sacc_pkg::CTRL_DONE_POS]   = done_ff;
            nxt_rdata[sacc_pkg::CTRL_START_POS]  = busy_ff;
            nxt_rdata[sacc_pkg::CTRL_CHAN_HI:sacc_pkg::CTRL_CHAN_LO] = chan_ff;
        end else if (sfr_req.rd && (sfr_req.addr == sacc_pkg::ADDR_RES_HIGH)) begin
            nxt_rdata = result_ff[sacc_pkg::RES_W-1:sacc_pkg::RES8_LSB];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff         <= sacc_pkg::ST_IDLE;
            done_ff          <= 1'b0;
            busy_ff          <= 1'b0;
            mode8_ff         <= 1'b0;
            chan_ff          <= '0;
            sample_switch_ff <= 1'b0;
            mux_en_ff        <= 1'b0;
            result_ff        <= '0;
            sfr_rdata_ff     <= sacc_pkg::RDATA_NONE;
        end else begin
            state_ff         <= nxt_state;
            done_ff          <= nxt_done;
            busy_ff          <= nxt_busy;
            mode8_ff         <= nxt_mode8;
            chan_ff          <= nxt_chan;
            sample_switch_ff <= nxt_sample;
            mux_en_ff        <= nxt_mux_en;
            result_ff        <= nxt_result;
            sfr_rdata_ff     <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Remembers an abort since the last start, so timing checks can excuse it
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            abort_seen_ff <= 1'b0;
        end else begin
            abort_seen_ff <= start_ev ? 1'b0 : (abort_seen_ff || abort_ev);
        end
    end

    sequence s_start10;
        start_ev && !pwr.eight_bit_mode_select;
    endsequence

    sequence s_start8;
        start_ev && pwr.eight_bit_mode_select;
    endsequence

    a_done_ten_bit: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_start10 |-> ##51 ($rose(done_ff) || abort_seen_ff))
        else $error("done flag not set 50 cycles after a 10-bit start");

    a_done_eight_bit: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_start8 |-> ##25 ($rose(done_ff) || abort_seen_ff))
        else $error("done flag not set 24 cycles after an 8-bit start");

    a_busy_after_done: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        ($rose(done_ff) && busy_ff) |=> !busy_ff)
        else $error("busy did not clear right after done");

    a_busy_rises: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_start10 ##1 conv_en |=> busy_ff)
        else $error("busy not high one cycle after start");

    a_done_hw_only: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(done_ff) |-> $past(state_ff) == sacc_pkg::ST_CONVERT)
        else $error("done flag set outside a conversion");

    a_done_sticky: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (done_ff && !wr_clears_done) |=> done_ff)
        else $error("done flag cleared without a software write");

    a_no_start_done: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (done_ff && !wr_clears_done && state_ff == sacc_pkg::ST_IDLE) |=> $stable(state_ff))
        else $error("conversion started while done flag set");

    a_sample_window: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        ($fell(sample_switch_ff) && state_ff == sacc_pkg::ST_CONVERT)
        |-> ($past(sample_switch_ff, 8) && !$past(sample_switch_ff, 9)))
        else $error("sampling switch not closed for eight cycles");

    a_chan_locked: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (done_ff || busy_ff) |=> $stable(chan_ff))
        else $error("channel changed while converter active");

    a_abort_keeps: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        abort_ev |=> (!busy_ff && $stable(result_ff) && $stable(done_ff)))
        else $error("abort disturbed result or left busy high");

endmodule
`default_nettype wire

// ---- verilog/sacc_pkg.sv ----
`default_nettype none
package sacc_pkg;

    // ------------------------------------------------------------------
    // Register addresses on the special function register bus
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL      = 8'hC5;
    localparam logic [7:0] ADDR_RES_HIGH  = 8'hC6;

    // ------------------------------------------------------------------
    // Control/status register field positions
    // ------------------------------------------------------------------
    localparam int CTRL_RES1_POS   = 7;
    localparam int CTRL_RES0_POS   = 6;
    localparam int CTRL_DONE_POS   = 4;
    localparam int CTRL_START_POS  = 3;
    localparam int CTRL_CHAN_HI    = 2;
    localparam int CTRL_CHAN_LO    = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RDATA_NONE = 8'h00;

    // ------------------------------------------------------------------
    // Conversion geometry and timing in machine cycles
    // ------------------------------------------------------------------
    localparam int RES_W       = 10;
    localparam int RES8_LSB    = 2;
    localparam int CHAN_W      = 3;
    localparam logic [2:0] CHAN_COUNT = 3'h6;
    localparam int CYC_W       = 6;
    localparam logic [5:0] INIT_CYC    = 6'h02;
    localparam logic [5:0] SAMPLE_CYC  = 6'h08;
    localparam logic [5:0] CONV_START  = INIT_CYC + SAMPLE_CYC;
    localparam logic [5:0] BIT_CYC_10  = 6'h04;
    localparam logic [5:0] BIT_CYC_8   = 6'h01;
    localparam logic [5:0] TOTAL_10    = 6'h32;
    localparam logic [5:0] TOTAL_8     = 6'h18;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sacc_sfr_req_t;

    typedef struct packed {
        logic idle_mode;
        logic power_down;
        logic idle_keep_converter_on;
        logic eight_bit_mode_select;
    } sacc_pwr_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_INIT,
        ST_SAMPLE,
        ST_CONVERT,
        ST_CLOSE
    } sacc_state_t;

endpackage
`default_nettype wire

// ---- verilog/sacc_cycle_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module sacc_cycle_timer #(
    parameter int W = 6
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    // Control
    input  wire logic         clr,
    input  wire logic         run,
    // Count of cycles since clear
    output logic [W-1:0]      count_ff
);

    logic [W-1:0] nxt_count;

    always_comb begin
        nxt_count = count_ff;
        if (clr) begin
            nxt_count = '0;
        end else if (run) begin
            nxt_count = count_ff + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

endmodule
`default_nettype wire

// ---- verilog/sacc_sar_reg.sv ----
`timescale 1ns/1ps
`default_nettype none
module sacc_sar_reg #(
    parameter int W    = 10,
    parameter int LSB8 = 2
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    // Sequencing
    input  wire logic         load,
    input  wire logic         step,
    input  wire logic         mode8,
    input  wire logic         comp_above,
    // Trial code to the ladder, and code with the pending decision applied
    output logic [W-1:0]      trial_ff,
    output logic [W-1:0]      decided
);

    logic [W-1:0] mask_ff;
    logic [W-1:0] nxt_mask;
    logic [W-1:0] nxt_trial;
    logic [W-1:0] floor_mask;

    always_comb begin
        floor_mask = mode8 ? ~((W'(1) << LSB8) - W'(1)) : '1;
        // Bit under test stays only if the input lies above the trial level
        decided   = comp_above ? trial_ff : (trial_ff & ~mask_ff);
        nxt_mask  = mask_ff;
        nxt_trial = trial_ff;
        if (load) begin
            nxt_mask  = W'(1) << (W - 1);
            nxt_trial = W'(1) << (W - 1);
        end else if (step && (mask_ff != '0)) begin
            nxt_mask  = (mask_ff >> 1) & floor_mask;
            nxt_trial = decided | nxt_mask;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_ff  <= '0;
            trial_ff <= '0;
        end else begin
            mask_ff  <= nxt_mask;
            trial_ff <= nxt_trial;
        end
    end

endmodule
`default_nettype wire

// ---- dv/sacc_analog_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sacc_analog_model (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    // Input level of each analog channel, in result codes
    input  wire logic [5:0][9:0]       level,
    // Front end controls from the converter
    input  wire logic [2:0]            chan_ff,
    input  wire logic                  mux_en_ff,
    input  wire logic                  sample_switch_ff,
    input  wire logic [9:0]            dac_code,
    // Comparator
    output logic                       comp_above
);
    logic [9:0] held_ff;

    // binary channel sampling
    // The hold capacitor keeps its charge once the switch opens
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            held_ff <= 10'h000;
        end else if (sample_switch_ff && mux_en_ff && chan_ff < 3'h6) begin
            held_ff <= level[chan_ff];
        end
    end

    assign comp_above = held_ff > dac_code;
endmodule
`default_nettype wire

// ---- dv/sacc_conv_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sacc_conv_ctrl_tb_top;
    localparam logic [7:0] CT = sacc_pkg::ADDR_CTRL;
    localparam logic [7:0] RH = sacc_pkg::ADDR_RES_HIGH;
    logic                    sys_clk;
    logic                    sys_rst;
    sacc_pkg::sacc_sfr_req_t sfr_req;
    logic [7:0]              sfr_rdata_ff;
    sacc_pkg::sacc_pwr_t     pwr;
    logic                    irq_enable;
    logic                    conv_irq_req;
    logic                    comp_above;
    logic [2:0]              chan_ff;
    logic                    mux_en_ff;
    logic                    sample_switch_ff;
    logic [9:0]              dac_code;
    logic [5:0][9:0]         level;
    logic [9:0]              last_r;
    int                      fails;
    int                      checks_done;
    int                      sw_cnt;
    int                      mx_cnt;

    sacc_conv_ctrl DUT (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
        .sfr_rdata_ff(sfr_rdata_ff), .pwr(pwr), .irq_enable(irq_enable),
        .conv_irq_req(conv_irq_req), .comp_above(comp_above), .chan_ff(chan_ff),
        .mux_en_ff(mux_en_ff), .sample_switch_ff(sample_switch_ff), .dac_code(dac_code)
    );
    sacc_analog_model AFE (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .level(level), .chan_ff(chan_ff),
        .mux_en_ff(mux_en_ff), .sample_switch_ff(sample_switch_ff),
        .dac_code(dac_code), .comp_above(comp_above)
    );

    always #5 sys_clk = ~sys_clk;

    // Sampled mid-cycle so the count never races the clock edge
    always @(negedge sys_clk) if (sample_switch_ff === 1'h1) sw_cnt++;
    always @(negedge sys_clk) if (mux_en_ff === 1'h1) mx_cnt++;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [9:0] exp_res(input logic [9:0] v, input logic m8);
        logic [9:0] r;
        logic [9:0] t;
        r = 10'h000;
        for (int b = 9; b >= (m8 ? 2 : 0); b--) begin
            t = r | (10'h001 << b);
            if (v > t) begin
                r = t;
            end
        end
        return r;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_req <= '{1'h1, 1'h0, a, d};
        @(posedge sys_clk);
        sfr_req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        sfr_req <= '{1'h0, 1'h1, a, 8'h00};
        @(posedge sys_clk);
        sfr_req <= '0;
        #1;
        chk(sfr_rdata_ff, exp);
    endtask

    task automatic wait_irq(input int exp);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (conv_irq_req !== 1'h1 && n < 300);
        chk(16'(n), 16'(exp));
        if (n >= 300) end_sim;
    endtask

    task automatic fin(input logic [2:0] c, input logic m8);
        last_r = exp_res(level[c], m8);
        rd(CT, {last_r[1:0], 3'h2, c});
        rd(RH, last_r[9:2]);
        chk(16'(chan_ff), 16'(c));
    endtask

    task automatic run(input logic [2:0] c, input logic m8);
        sw_cnt = 0;
        mx_cnt = 0;
        wr(CT, {5'h01, c});
        wait_irq(m8 ? 24 : 50);
        chk(16'(sw_cnt), 16'h0008);
        chk(16'(mx_cnt), 16'h0008);
        fin(c, m8);
    endtask

    task automatic clr(input logic [2:0] c);
        wr(CT, {5'h00, c});
        #1;
        chk(conv_irq_req, 1'h0);
    endtask

    task automatic end_sim;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'h0;
        sys_rst = 1'h1;
        sfr_req = '0;
        pwr = '0;
        irq_enable = 1'h1;
        level = {10'h3FF, 10'h000, 10'h155, 10'h2AA, 10'h001, 10'h200};
        fails = 0;
        checks_done = 0;
        sw_cnt = 0;
        mx_cnt = 0;
        last_r = 10'h000;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'h0;
        rd(CT, 8'h00);
        rd(RH, 8'h00);
        rd(8'h00, 8'h00);
        wr(CT, 8'h27);
        rd(CT, 8'h07);
        for (int c = 0; c < 8; c++) begin
            wr(CT, 8'(c));
            rd(CT, 8'(c));
        end
        for (int c = 0; c < 6; c++) begin
            run(3'(c), 1'h0);
            clr(3'(c));
        end
        // Done held: start and channel write refused; a start that clears done runs on the old channel
        run(3'h2, 1'h0);
        @(posedge sys_clk);
        irq_enable <= 1'h0;
        #1 chk(conv_irq_req, 1'h0);
        @(posedge sys_clk);
        irq_enable <= 1'h1;
        wr(CT, 8'h1D);
        repeat (60) @(posedge sys_clk);
        fin(3'h2, 1'h0);
        chk(conv_irq_req, 1'h1);
        wr(CT, 8'h0D);
        wait_irq(50);
        fin(3'h2, 1'h0);
        clr(3'h2);
        // Busy: status reads high, restart and channel change refused
        wr(CT, 8'h09);
        repeat (5) @(posedge sys_clk);
        rd(CT, {last_r[1:0], 3'h1, 3'h1});
        wr(CT, 8'h0C);
        wait_irq(41);
        fin(3'h1, 1'h0);
        clr(3'h1);
        @(posedge sys_clk);
        pwr <= 4'h1;
        run(3'h5, 1'h1);
        clr(3'h5);
        run(3'h3, 1'h1);
        clr(3'h3);
        @(posedge sys_clk);
        pwr <= 4'hA;
        run(3'h4, 1'h0);
        clr(3'h4);
        // Power-down, then idle without keep, abort a running conversion
        for (int m = 0; m < 2; m++) begin
            @(posedge sys_clk);
            pwr <= 4'h0;
            wr(CT, 8'h08);
            repeat (20) @(posedge sys_clk);
            pwr <= (m == 1) ? 4'h8 : 4'h4;
            repeat (2) @(posedge sys_clk);
            pwr <= 4'h0;
            repeat (60) @(posedge sys_clk);
            rd(CT, {last_r[1:0], 3'h0, 3'h0});
        end
        wr(CT, 8'h0B);
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'h0;
        #1 chk(sample_switch_ff, 1'h0);
        rd(CT, 8'h00);
        run(3'h0, 1'h0);
        clr(3'h0);
        end_sim;
    end
endmodule
`default_nettype wire
